// ==== inc/timer_regs.svh ====
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ****************************************
// widths and channel counts
// ****************************************
`define TMR_CNT_W        32
`define TMR_NUM_CH       4
`define TMR_CAP_PINS     3
`define TMR_MAT_PINS     2
`define TMR_NUM_FLAGS    8

// ****************************************
// flag field positions
// ****************************************
`define TMR_FLAG_MATCH_LSB 0
`define TMR_FLAG_CAPT_LSB  4

// ****************************************
// reset values, plus the count step of one
// ****************************************
`define TMR_COUNT_RST    32'h0000_0000
`define TMR_FLAGS_RST    8'h00
`define TMR_COUNT_ONE    32'h0000_0001

// ****************************************
// external match action codes
// ****************************************
`define TMR_ACT_NONE     2'h0
`define TMR_ACT_LOW      2'h1
`define TMR_ACT_HIGH     2'h2
`define TMR_ACT_TOGGLE   2'h3

// ****************************************
// counter state codes, one-hot
// ****************************************
`define TMR_ST_IDLE      3'h1
`define TMR_ST_RUN       3'h2
`define TMR_ST_HALT      3'h4

`endif

// ==== inc/timer_pkg.sv ====
`include "timer_regs.svh"

package timer_pkg;

	// ****************************************
	// data types
	// ****************************************
	typedef logic [`TMR_CNT_W-1:0] count_t;
	typedef count_t [`TMR_NUM_CH-1:0] count_bank_t;

	// per match channel: interrupt, reset and stop options
	typedef struct packed {
		logic irq_en;
		logic reset_en;
		logic stop_en;
	} match_ctrl_t;

	// per capture channel: edges that capture, interrupt option
	typedef struct packed {
		logic rise_en;
		logic fall_en;
		logic irq_en;
	} capture_ctrl_t;

	typedef match_ctrl_t [`TMR_NUM_CH-1:0] match_ctrl_bank_t;
	typedef capture_ctrl_t [`TMR_NUM_CH-1:0] capture_ctrl_bank_t;

	typedef enum logic [1:0] {
		ACT_NONE   = `TMR_ACT_NONE,
		ACT_LOW    = `TMR_ACT_LOW,
		ACT_HIGH   = `TMR_ACT_HIGH,
		ACT_TOGGLE = `TMR_ACT_TOGGLE
	} ext_action_t;

	typedef ext_action_t [`TMR_NUM_CH-1:0] external_match_control_t;

	typedef enum logic [2:0] {
		ST_IDLE = `TMR_ST_IDLE,
		ST_RUN  = `TMR_ST_RUN,
		ST_HALT = `TMR_ST_HALT
	} run_state_t;

endpackage

// ==== rtl/capture_edge_detect.sv ====
`timescale 1ns/10ps
`include "timer_regs.svh"

// ****************************************
// capture input: pin merge, sync, edge qualify
// ****************************************
module capture_edge_detect (
	input  wire logic                      clk_sys_in,
	input  wire logic                      resetn_in,
	input  wire logic [`TMR_CAP_PINS-1:0]  pins_in,
	input  wire logic [`TMR_CAP_PINS-1:0]  pin_select_in,
	input  wire timer_pkg::capture_ctrl_t  ctrl_in,
	output logic                           event_out
);
	import timer_pkg::*;

	logic merged;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;

	// selected pins act as one input
	assign merged = |(pins_in & pin_select_in);

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= merged;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// one pulse per qualifying transition
	assign event_out = (ctrl_in.rise_en & sync2_q & ~prev_q) |
		(ctrl_in.fall_en & ~sync2_q & prev_q);

endmodule

// ==== rtl/match_compare.sv ====
`timescale 1ns/10ps

// ****************************************
// one match channel: compare and pin action
// ****************************************
module match_compare (
	input  wire logic                 tick_in,
	input  wire timer_pkg::count_t    next_count_in,
	input  wire timer_pkg::count_t    match_value_in,
	input  wire timer_pkg::ext_action_t action_in,
	input  wire logic                 out_state_in,
	output logic                      hit_out,
	output logic                      out_state_d_out
);
	import timer_pkg::*;

	// new pin level for a given action
	function automatic logic apply_action(ext_action_t act, logic cur);
		case (act)
			ACT_LOW:    apply_action = 1'b0;
			ACT_HIGH:   apply_action = 1'b1;
			ACT_TOGGLE: apply_action = ~cur;
			default:    apply_action = cur;
		endcase
	endfunction

	// hit only when the count steps onto the value, so a parked count fires once
	assign hit_out = tick_in & (next_count_in == match_value_in);

	// action applied in the same step as the count reaches the value
	assign out_state_d_out = hit_out ? apply_action(action_in, out_state_in) :
		out_state_in;

endmodule

// ==== rtl/timer_capture_match_unit.sv ====
`timescale 1ns/10ps
`include "timer_regs.svh"


module timer_capture_match_unit (
	input  wire logic                               clk_sys_in,
	input  wire logic                               resetn_in,
	// control
	input  wire logic                               counter_enable_in,
	input  wire timer_pkg::count_t                  prescale_limit_in,
	input  wire timer_pkg::count_bank_t             match_values_in,
	input  wire timer_pkg::match_ctrl_bank_t        match_ctrl_in,
	input  wire timer_pkg::capture_ctrl_bank_t      capture_ctrl_in,
	input  wire timer_pkg::external_match_control_t external_match_control_in,
	input  wire logic [`TMR_NUM_FLAGS-1:0]          flag_clear_in,
	// pin routing
	input  wire logic [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] capture_inputs_in,
	input  wire logic [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] capture_pin_select_in,
	input  wire logic [`TMR_NUM_CH-1:0][`TMR_MAT_PINS-1:0] match_pin_select_in,
	// status
	output timer_pkg::count_t                       timer_count_out,
	output timer_pkg::count_t                       prescale_count_out,
	output timer_pkg::count_bank_t                  capture_values_out,
	output logic [`TMR_NUM_FLAGS-1:0]               interrupt_flags_out,
	output logic                                    running_out,
	output logic                                    halted_out,
	// match pins
	output logic [`TMR_NUM_CH-1:0]                  match_outputs_out,
	output logic [`TMR_NUM_CH-1:0][`TMR_MAT_PINS-1:0] match_pins_out
);
	import timer_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	run_state_t                     state_q;
	run_state_t                     state_d;
	count_t                         timer_count_q;
	count_t                         timer_count_d;
	count_t                         prescale_count_q;
	count_t                         prescale_count_d;
	count_t                         count_step;
	count_bank_t                    capture_values_q;
	logic [`TMR_NUM_FLAGS-1:0]      interrupt_flags_q;
	logic [`TMR_NUM_FLAGS-1:0]      flag_set;
	logic [`TMR_NUM_CH-1:0]         match_state_q;
	logic [`TMR_NUM_CH-1:0]         match_state_d;
	logic [`TMR_NUM_CH-1:0][`TMR_MAT_PINS-1:0] match_pins_q;
	logic [`TMR_NUM_CH-1:0]         match_hit;
	logic [`TMR_NUM_CH-1:0]         capture_event;
	logic [`TMR_NUM_CH-1:0]         reset_due;
	logic                           running;
	logic                           tick;
	logic                           stop_hit;
	logic                           wrap_to_zero;
	logic                           running_q;
	logic                           halted_q;

	// ****************************************
	// run control
	// ****************************************

	// counting happens only in the run state, which needs enable high
	assign running = (state_q == ST_RUN) & counter_enable_in;

	// stop request from any channel configured to halt
	always_comb begin
		stop_hit = 1'b0;
		for (int i = 0; i < `TMR_NUM_CH; i++) begin
			stop_hit = stop_hit | (match_hit[i] & match_ctrl_in[i].stop_en);
		end
	end

	// a halted timer stays parked until software drops the enable,
	// so a stale enable cannot silently restart it
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (counter_enable_in) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!counter_enable_in) begin
					state_d = ST_IDLE;
				end else if (stop_hit) begin
					state_d = ST_HALT;
				end
			end
			ST_HALT: begin
				if (!counter_enable_in) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// status bits registered from the next state, so they move with
	// the state register and leave the block straight from a flop
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			running_q <= 1'b0;
			halted_q  <= 1'b0;
		end else begin
			running_q <= (state_d == ST_RUN);
			halted_q  <= (state_d == ST_HALT);
		end
	end

	// ****************************************
	// prescaler
	// ****************************************

	// tick when the prescaler has counted up to its limit
	assign tick = running & (prescale_count_q == prescale_limit_in);

	// prescaler counts clock cycles, holds when disabled
	always_comb begin
		prescale_count_d = prescale_count_q;
		if (running) begin
			if (tick) begin
				prescale_count_d = `TMR_COUNT_RST;
			end else begin
				prescale_count_d = prescale_count_q + `TMR_COUNT_ONE;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prescale_count_q <= `TMR_COUNT_RST;
		end else begin
			prescale_count_q <= prescale_count_d;
		end
	end

	// ****************************************
	// main count
	// ****************************************

	// reset-on-match: the count sits on the value for one full
	// prescale period, then wraps to zero instead of stepping on
	generate
		for (genvar i = 0; i < `TMR_NUM_CH; i++) begin : g_reset
			assign reset_due[i] = match_ctrl_in[i].reset_en &
				(timer_count_q == match_values_in[i]);
		end
	endgenerate

	assign wrap_to_zero = |reset_due;

	// value the count moves to on the next tick
	assign count_step = wrap_to_zero ? `TMR_COUNT_RST :
		timer_count_q + `TMR_COUNT_ONE;

	assign timer_count_d = tick ? count_step : timer_count_q;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			timer_count_q <= `TMR_COUNT_RST;
		end else begin
			timer_count_q <= timer_count_d;
		end
	end

	// ****************************************
	// match channels
	// ****************************************

	// each channel compares against the stepped count
	generate
		for (genvar i = 0; i < `TMR_NUM_CH; i++) begin : g_match
			match_compare u_match (
				.tick_in         (tick),
				.next_count_in   (count_step),
				.match_value_in  (match_values_in[i]),
				.action_in       (external_match_control_in[i]),
				.out_state_in    (match_state_q[i]),
				.hit_out         (match_hit[i]),
				.out_state_d_out (match_state_d[i])
			);
		end
	endgenerate

	// match pin levels, held between matches
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			match_state_q <= '0;
		end else begin
			match_state_q <= match_state_d;
		end
	end

	// every selected pin carries the same level; unselected pins rest low.
	// taken from the next state so pins and level change together
	generate
		for (genvar i = 0; i < `TMR_NUM_CH; i++) begin : g_pins
			always_ff @(posedge clk_sys_in or negedge resetn_in) begin
				if (!resetn_in) begin
					match_pins_q[i] <= '0;
				end else begin
					match_pins_q[i] <= match_pin_select_in[i] &
						{`TMR_MAT_PINS{match_state_d[i]}};
				end
			end
		end
	endgenerate

	// ****************************************
	// capture channels
	// ****************************************

	// edge qualification per channel
	generate
		for (genvar i = 0; i < `TMR_NUM_CH; i++) begin : g_capture
			capture_edge_detect u_cap (
				.clk_sys_in    (clk_sys_in),
				.resetn_in     (resetn_in),
				.pins_in       (capture_inputs_in[i]),
				.pin_select_in (capture_pin_select_in[i]),
				.ctrl_in       (capture_ctrl_in[i]),
				.event_out     (capture_event[i])
			);

			// snapshot of the count as it stands at the event;
			// capture works even while the timer is stopped
			always_ff @(posedge clk_sys_in or negedge resetn_in) begin
				if (!resetn_in) begin
					capture_values_q[i] <= `TMR_COUNT_RST;
				end else if (capture_event[i]) begin
					capture_values_q[i] <= timer_count_q;
				end
			end
		end
	endgenerate

	// ****************************************
	// interrupt flags
	// ****************************************

	// events that may raise a flag, each gated by its own option
	always_comb begin
		flag_set = '0;
		for (int i = 0; i < `TMR_NUM_CH; i++) begin
			flag_set[`TMR_FLAG_MATCH_LSB + i] = match_hit[i] & match_ctrl_in[i].irq_en;
			flag_set[`TMR_FLAG_CAPT_LSB + i] = capture_event[i] &
				capture_ctrl_in[i].irq_en;
		end
	end

	// write-one-to-clear; a set in the clearing cycle wins
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			interrupt_flags_q <= `TMR_FLAGS_RST;
		end else begin
			interrupt_flags_q <= (interrupt_flags_q & ~flag_clear_in) | flag_set;
		end
	end

	// ****************************************
	// outputs, all straight from flops
	// ****************************************

	// no per-instance constants: a second timer is just another copy
	assign timer_count_out     = timer_count_q;
	assign prescale_count_out  = prescale_count_q;
	assign capture_values_out  = capture_values_q;
	assign interrupt_flags_out = interrupt_flags_q;
	assign running_out         = running_q;
	assign halted_out          = halted_q;
	assign match_outputs_out   = match_state_q;
	assign match_pins_out      = match_pins_q;

endmodule

// ==== testbench/cap_pin_source.sv ====
`timescale 1ns/10ps
`include "timer_regs.svh"

// ****************************************
// far side: capture pin source
// ****************************************
module cap_pin_source (
	input  wire logic                                      clk_sys_in,
	input  wire logic [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] level_in,
	output logic      [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] pins_out
);
	logic [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] level_q;

	// level taken at the rising edge, shown at the next falling edge,
	// so bench and pins never race within one time step
	initial pins_out = '0;
	always @(posedge clk_sys_in) begin
		level_q <= level_in;
	end
	always @(negedge clk_sys_in) begin
		pins_out <= level_q;
	end
endmodule

// ==== testbench/tcmu_asserts.sv ====
`timescale 1ns/10ps
`include "timer_regs.svh"

// ****************************************
// port checker
// ****************************************
module tcmu_asserts (
	input wire logic                                      clk_sys_in,
	input wire logic                                      resetn_in,
	input wire logic                                      counter_enable_in,
	input wire timer_pkg::count_t                         prescale_limit_in,
	input wire timer_pkg::count_bank_t                    match_values_in,
	input wire timer_pkg::match_ctrl_bank_t               match_ctrl_in,
	input wire timer_pkg::capture_ctrl_bank_t             capture_ctrl_in,
	input wire timer_pkg::external_match_control_t        external_match_control_in,
	input wire logic [`TMR_NUM_FLAGS-1:0]                 flag_clear_in,
	input wire logic [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] capture_inputs_in,
	input wire logic [`TMR_NUM_CH-1:0][`TMR_CAP_PINS-1:0] capture_pin_select_in,
	input wire logic [`TMR_NUM_CH-1:0][`TMR_MAT_PINS-1:0] match_pin_select_in,
	input wire timer_pkg::count_t                         timer_count_out,
	input wire timer_pkg::count_t                         prescale_count_out,
	input wire logic [`TMR_NUM_FLAGS-1:0]                 interrupt_flags_out,
	input wire logic                                      running_out,
	input wire logic                                      halted_out,
	input wire logic [`TMR_NUM_CH-1:0]                    match_outputs_out,
	input wire logic [`TMR_NUM_CH-1:0][`TMR_MAT_PINS-1:0] match_pins_out
);
	import timer_pkg::*;
	logic                                      tick;
	logic                                      wrap;
	logic                                      cap_or;
	logic [`TMR_NUM_CH-1:0][`TMR_MAT_PINS-1:0] pins_exp;

	// tick and reset-on-match seen one edge ahead
	always_comb begin
		tick = running_out & counter_enable_in & (prescale_count_out == prescale_limit_in);
		wrap = 1'b0;
		cap_or = |(capture_inputs_in[2] & capture_pin_select_in[2]);
		for (int i = 0; i < `TMR_NUM_CH; i++) begin
			wrap = wrap | (match_ctrl_in[i].reset_en & (timer_count_out == match_values_in[i]));
			pins_exp[i] = match_pin_select_in[i] & {2{match_outputs_out[i]}};
		end
	end

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	a_hold_when_off: assert property (!counter_enable_in |=> $stable(timer_count_out)
		&& $stable(prescale_count_out)) else $error("count moved while disabled");
	a_prescale_wrap: assert property (tick |=> prescale_count_out == 32'h0000_0000)
		else $error("prescale did not return to zero");
	a_count_step: assert property (tick && !wrap |=>
		timer_count_out == $past(timer_count_out) + 32'h0000_0001) else $error("bad step");
	a_reset_wrap: assert property (tick && wrap |=> timer_count_out == 32'h0000_0000)
		else $error("count did not wrap");
	a_halt_freeze: assert property (halted_out |=> $stable(timer_count_out)
		&& $stable(prescale_count_out)) else $error("count moved while halted");
	a_flags_sticky: assert property (1'b1 |=> ((($past(interrupt_flags_out)
		& ~$past(flag_clear_in)) & ~interrupt_flags_out) == 8'h00)) else $error("flag lost");
	a_pins_follow: assert property ($stable(match_pin_select_in) |->
		match_pins_out == pins_exp) else $error("match pins differ from level");
	a_match_high: assert property (tick && !wrap && external_match_control_in[0] == ACT_HIGH
		&& timer_count_out + 32'h0000_0001 == match_values_in[0] |=> match_outputs_out[0])
		else $error("match pin not driven high");
	a_capture_flag: assert property ($rose(cap_or) && capture_ctrl_in[2].rise_en
		&& capture_ctrl_in[2].irq_en |-> ##[1:4] interrupt_flags_out[6])
		else $error("capture flag missing");

	c_halt: cover property ($rose(halted_out));
	c_wrap: cover property (tick && wrap);
	c_capture: cover property ($rose(interrupt_flags_out[6]));
endmodule

bind timer_capture_match_unit tcmu_asserts u_chk (.clk_sys_in, .resetn_in, .counter_enable_in,
	.prescale_limit_in, .match_values_in, .match_ctrl_in, .capture_ctrl_in,
	.external_match_control_in, .flag_clear_in, .capture_inputs_in, .capture_pin_select_in,
	.match_pin_select_in, .timer_count_out, .prescale_count_out, .interrupt_flags_out,
	.running_out, .halted_out, .match_outputs_out, .match_pins_out);

// ==== testbench/timer_capture_match_unit_test.sv ====
`timescale 1ns/10ps
`include "timer_regs.svh"

module timer_capture_match_unit_test;
	import timer_pkg::*;
	logic clk_sys_in;
	logic resetn_in;
	logic counter_enable_in;
	count_t prescale_limit_in;
	count_bank_t match_values_in;
	match_ctrl_bank_t match_ctrl_in;
	capture_ctrl_bank_t capture_ctrl_in;
	external_match_control_t external_match_control_in;
	logic [7:0] flag_clear_in;
	logic [3:0][2:0] capture_inputs_in;
	logic [3:0][2:0] cap_level;
	logic [3:0][2:0] capture_pin_select_in;
	logic [3:0][1:0] match_pin_select_in;
	count_t timer_count_out;
	count_t prescale_count_out;
	count_bank_t capture_values_out;
	logic [7:0] interrupt_flags_out;
	logic running_out;
	logic halted_out;
	logic [3:0] match_outputs_out;
	logic [3:0][1:0] match_pins_out;
	int err_total = 0;
	int checks = 0;
	int cycles = 0;

	timer_capture_match_unit DUT (.clk_sys_in, .resetn_in, .counter_enable_in,
		.prescale_limit_in, .match_values_in, .match_ctrl_in, .capture_ctrl_in,
		.external_match_control_in, .flag_clear_in, .capture_inputs_in,
		.capture_pin_select_in, .match_pin_select_in, .timer_count_out, .prescale_count_out,
		.capture_values_out, .interrupt_flags_out, .running_out, .halted_out,
		.match_outputs_out, .match_pins_out);
	cap_pin_source u_pins (.clk_sys_in, .level_in(cap_level), .pins_out(capture_inputs_in));

	// ****************************************
	// clock, watchdog, helpers
	// ****************************************
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	// a hang is cut short long after the scenarios should end
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// defaults first, so it also serves at time zero
	task automatic apply_reset();
		resetn_in = 1'b0;
		counter_enable_in = 1'b0;
		prescale_limit_in = 32'h0000_0000;
		match_values_in = '1;
		match_ctrl_in = '0;
		capture_ctrl_in = '0;
		external_match_control_in = {4{ACT_NONE}};
		flag_clear_in = 8'h00;
		cap_level = '0;
		capture_pin_select_in = '0;
		match_pin_select_in = '0;
		repeat (20) @(negedge clk_sys_in);
		resetn_in = 1'b1;
	endtask

	task automatic wait_bit(input int b, output int n);
		n = 0;
		while (interrupt_flags_out[b] !== 1'b1 && n < 200) begin
			@(negedge clk_sys_in);
			n++;
		end
	endtask

	task automatic cycles_to_step(output int n);
		count_t c0;
		c0 = timer_count_out;
		n = 0;
		while (timer_count_out === c0 && n < 64) begin
			@(negedge clk_sys_in);
			n++;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_prescale();
		int n;
		count_t c0;
		count_t p0;
		apply_reset();
		prescale_limit_in = 32'h0000_0003;
		counter_enable_in = 1'b1;
		cycles_to_step(n);
		c0 = timer_count_out;
		cycles_to_step(n);
		check(n, 4);
		check(timer_count_out, c0 + 32'h0000_0001);
		check(running_out, 1'b1);
		repeat (2) @(negedge clk_sys_in);
		check(prescale_count_out, 32'h0000_0002);
		counter_enable_in = 1'b0;
		c0 = timer_count_out;
		p0 = prescale_count_out;
		repeat (12) @(negedge clk_sys_in);
		check(timer_count_out, c0);
		check(prescale_count_out, p0);
		check(running_out, 1'b0);
	endtask

	task automatic t_reset_match();
		int n;
		apply_reset();
		match_values_in[0] = 32'h0000_0005;
		match_ctrl_in[0] = 3'h6;
		external_match_control_in[0] = ACT_HIGH;
		match_pin_select_in[0] = 2'h2;
		match_values_in[1] = 32'h0000_0003;
		external_match_control_in[1] = ACT_TOGGLE;
		counter_enable_in = 1'b1;
		wait_bit(0, n);
		check(timer_count_out, 32'h0000_0005);
		check(match_outputs_out, 4'h3);
		check(match_pins_out[0], 2'h2);
		check(interrupt_flags_out[1], 1'b0);
		@(negedge clk_sys_in);
		check(timer_count_out, 32'h0000_0000);
		counter_enable_in = 1'b0;
		flag_clear_in = 8'h01;
		@(negedge clk_sys_in);
		flag_clear_in = 8'h00;
		check(interrupt_flags_out, 8'h00);
	endtask

	// follows t_reset_match: both pins high, count parked at zero
	task automatic t_stop_match();
		int n;
		count_t c0;
		match_ctrl_in[0] = 3'h0;
		external_match_control_in[0] = ACT_LOW;
		external_match_control_in[1] = ACT_NONE;
		match_values_in[2] = 32'h0000_0009;
		match_ctrl_in[2] = 3'h5;
		counter_enable_in = 1'b1;
		wait_bit(2, n);
		check(timer_count_out, 32'h0000_0009);
		check(match_outputs_out[1:0], 2'h2);
		c0 = timer_count_out;
		repeat (6) @(negedge clk_sys_in);
		check(halted_out, 1'b1);
		check(timer_count_out, c0);
	endtask

	task automatic t_capture();
		int n;
		count_t c2;
		count_t c3;
		apply_reset();
		capture_ctrl_in[2] = 3'h5;
		capture_ctrl_in[3] = 3'h6;
		capture_pin_select_in[2] = 3'h5;
		capture_pin_select_in[3] = 3'h1;
		counter_enable_in = 1'b1;
		repeat (10) @(negedge clk_sys_in);
		cap_level[2] = 3'h4;
		cap_level[3] = 3'h1;
		wait_bit(6, n);
		check(capture_values_out[2], timer_count_out - 32'h0000_0001);
		check(capture_values_out[3], capture_values_out[2]);
		check(interrupt_flags_out[7], 1'b0);
		c2 = capture_values_out[2];
		c3 = capture_values_out[3];
		cap_level[2] = 3'h5;
		cap_level[3] = 3'h0;
		repeat (8) @(negedge clk_sys_in);
		check(capture_values_out[2], c2);
		check(capture_values_out[3], c3 + 32'(n));
		flag_clear_in = 8'h40;
		@(negedge clk_sys_in);
		flag_clear_in = 8'h00;
		check(interrupt_flags_out[6], 1'b0);
	endtask

	initial begin
		apply_reset();
		t_prescale();
		t_reset_match();
		t_stop_match();
		t_capture();
		tally_and_finish();
	end
endmodule
